//--- pms_host.sv
// model of processor hints and ramp comparator facing the selector
`timescale 1ns/1ps
module pms_host (
  // clock
  input  wire logic       clock_i,
  // commands from the bench: hint pair and code, and ramp on length
  input  wire logic [8:0] cmd_i,
  input  wire logic [7:0] on_len_i,
  // gate feedback
  input  wire logic       gate_i,
  // pins
  output logic [8:0]      pins_o,
  output logic            ramp_end_o
);
  logic [7:0] cnt = 8'h00;
  always @(posedge clock_i) begin
    pins_o <= cmd_i;
    cnt <= gate_i ? cnt + 8'h01 : 8'h00;
    ramp_end_o <= gate_i && (cnt >= on_len_i);
  end
endmodule // pms_host

//--- pms_mclk.sv
// master clock generator: period follows the voltage code
`timescale 1ns/1ps
module pms_mclk (
  input wire logic clock_i,
  input wire logic rst_b_i,
  pms_mclk_if.gen  mc
);
  typedef struct packed {
    logic [pms_pkg::MCLK_W-1:0] cnt;
    logic                       tick;
  } pms_mclk_s;

  pms_mclk_s st;
  pms_mclk_s next_st;
  logic [pms_pkg::MCLK_W-1:0] period;

  // lower code is a lower voltage, so the period is longer
  always_comb begin
    period = pms_pkg::MCLK_W'(pms_pkg::MCLK_BASE)
           + pms_pkg::MCLK_W'(pms_pkg::MCLK_STEP) * {3'h0, ~mc.code};
  end

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt >= period - 10'h001) begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 10'h001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign mc.tick = st.tick;

  tick_period_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    st.tick |-> st.cnt == '0)
    else $error("tick without counter wrap");
endmodule // pms_mclk

//--- pms_mclk_if.sv
// interface: master clock tick and voltage code between modules
`timescale 1ns/1ps
interface pms_mclk_if;
  logic [pms_pkg::CODE_W-1:0] code;
  logic                       tick;
  modport gen (input code, output tick);
  modport use_ (output code, input tick);
endinterface

//--- pms_pkg.sv
// package: constants and types for the phase and mode selector
package pms_pkg;
  localparam int unsigned CODE_W       = 7;
  localparam int unsigned CLK_MHZ      = 250;
  // code transition window masking interval, in microseconds
  localparam int unsigned MASK_US      = 100;
  localparam int unsigned MASK_CYC     = MASK_US * CLK_MHZ;
  localparam int unsigned MASK_W       = 16;
  // master clock period in cycles at the highest code; grows as code falls
  localparam int unsigned MCLK_BASE    = 250;
  localparam int unsigned MCLK_STEP    = 2;
  localparam int unsigned MCLK_W       = 10;

  typedef enum logic [1:0] {
    PMS_RIPPLE = 2'b01,
    PMS_FIXED  = 2'b10
  } pms_mode_e;
endpackage

//--- pms_top.sv
// phase count and control mode selection with gate pulse steering
`timescale 1ns/1ps
module pms_top (
  input  wire logic                       clock_i,
  input  wire logic                       rst_b_i,
  // processor and system hints (pins)
  input  wire logic                       phase_count_strap_i,
  input  wire logic                       power_state_hint_i,
  input  wire logic                       deep_sleep_hint_i,
  input  wire logic [pms_pkg::CODE_W-1:0] voltage_code_i,
  // analog comparator results (pins)
  input  wire logic                       current_limit_i,
  input  wire logic                       ripple_trip_i,
  input  wire logic                       ramp_end_i,
  input  wire logic                       zero_current_i,
  // gate drive pulses
  output logic                            phase1_high_gate_o,
  output logic                            phase1_low_gate_o,
  output logic                            phase2_high_gate_o,
  output logic                            phase2_low_gate_o,
  // status
  output logic                            two_phase_o,
  output logic                            fixed_clock_mode_o,
  output logic                            ripple_triggered_mode_o,
  output logic                            dcm_allowed_o,
  output logic                            code_transition_o,
  output logic [pms_pkg::CODE_W-1:0]      voltage_code_o
);
  localparam int unsigned NSYNC = 7 + pms_pkg::CODE_W;

  typedef pms_pkg::pms_mode_e pms_mode_e_t;

  typedef struct packed {
    logic [NSYNC-1:0]           s1;
    logic [NSYNC-1:0]           s2;
    logic [NSYNC-1:0]           s3;
    logic [NSYNC-1:0]           clean;
    logic [pms_pkg::CODE_W-1:0] prev_code;
    logic [pms_pkg::MASK_W-1:0] mask_cnt;
    logic                       window;
    logic                       two_ph;
    pms_mode_e_t                mode;
    logic                       dcm;
    logic                       turn;
    logic                       hs1;
    logic                       hs2;
    logic                       ls1_off;
  } pms_top_s;

  pms_top_s st;
  pms_top_s next_st;
  pms_mclk_if mc ();

  pms_mclk u_mclk (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .mc      (mc.gen)
  );

  // synchronised pin views
  logic                       strap, psh, dsh, ilim, trip, rend, zc;
  logic [pms_pkg::CODE_W-1:0] code;
  assign {strap, psh, dsh, ilim, trip, rend, code} = st.clean[NSYNC-1:1];
  assign zc = st.clean[0];
  assign mc.code = st.prev_code;

  always_comb begin
    next_st = st;
    next_st.s1 = {phase_count_strap_i, power_state_hint_i, deep_sleep_hint_i,
                  current_limit_i, ripple_trip_i, ramp_end_i, voltage_code_i,
                  zero_current_i};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a change counts once stages two and three agree
    for (int i = 0; i < NSYNC; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.clean[i] = st.s3[i];
      end
    end
    // code compare restarts the transition window
    next_st.prev_code = code;
    if (code != st.prev_code) begin
      next_st.mask_cnt = pms_pkg::MASK_W'(pms_pkg::MASK_CYC - 1);
      next_st.window   = 1'b1;
    end else if (st.mask_cnt != '0) begin
      next_st.mask_cnt = st.mask_cnt - 16'h0001;
    end else begin
      next_st.window = 1'b0;
    end
    // phase count and method selection
    if (next_st.window) begin
      next_st.two_ph = !strap;
      next_st.mode   = pms_pkg::PMS_FIXED;
      next_st.dcm    = 1'b0;
    end else if (psh && !dsh) begin
      next_st.two_ph = !strap;
      next_st.mode   = pms_pkg::PMS_FIXED;
      next_st.dcm    = 1'b0;
    end else begin
      next_st.two_ph = 1'b0;
      next_st.mode   = ilim ? pms_pkg::PMS_FIXED : pms_pkg::PMS_RIPPLE;
      next_st.dcm    = dsh && !ilim;
    end
    // gate pulses, each phase tracked on its own
    if (st.mode == pms_pkg::PMS_FIXED) begin
      if (mc.tick) begin
        if (st.two_ph && st.turn) begin
          next_st.hs2 = 1'b1;
        end else begin
          next_st.hs1 = 1'b1;
        end
        next_st.turn = st.two_ph ? !st.turn : 1'b0;
      end
    end else if (trip) begin
      next_st.hs1 = 1'b1;
    end
    if (rend) begin
      // ramp end is shared; it ends whichever phase began last
      if (st.hs2 && !st.turn) begin
        next_st.hs2 = 1'b0;
      end else begin
        next_st.hs1 = 1'b0;
      end
    end
    if (!st.two_ph) begin
      next_st.hs2 = 1'b0;
    end
    if (next_st.hs1) begin
      next_st.ls1_off = 1'b0;
    end else if (st.dcm && zc) begin
      next_st.ls1_off = 1'b1;
    end else if (!st.dcm) begin
      next_st.ls1_off = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.mode <= pms_pkg::PMS_FIXED;
    end else begin
      st <= next_st;
    end
  end

  assign phase1_high_gate_o      = st.hs1;
  assign phase1_low_gate_o       = !st.hs1 && !st.ls1_off;
  assign phase2_high_gate_o      = st.hs2;
  assign phase2_low_gate_o       = st.two_ph && !st.hs2;
  assign two_phase_o             = st.two_ph;
  assign fixed_clock_mode_o      = st.mode == pms_pkg::PMS_FIXED;
  assign ripple_triggered_mode_o = st.mode == pms_pkg::PMS_RIPPLE;
  assign dcm_allowed_o           = st.dcm;
  assign code_transition_o       = st.window;
  assign voltage_code_o          = st.prev_code;

  strap_single_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    $past(strap) |-> !st.two_ph)
    else $error("two phases with strap high");
  window_fixed_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    st.window |-> st.mode == pms_pkg::PMS_FIXED && !st.dcm)
    else $error("transition not fixed-clock");
  code_opens_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    code != st.prev_code |=> st.window)
    else $error("code change did not open window");
  light_single_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    st.two_ph |-> st.mode == pms_pkg::PMS_FIXED)
    else $error("two phases not fixed-clock");
  ilim_fixed_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !next_st.window && !psh && ilim |=> st.mode == pms_pkg::PMS_FIXED)
    else $error("limit did not force fixed clock");
  sleep_ripple_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !next_st.window && dsh && !ilim
    |=> !st.two_ph && st.dcm && st.mode == pms_pkg::PMS_RIPPLE)
    else $error("deep sleep not single ripple");
  ripple_fire_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    st.mode == pms_pkg::PMS_RIPPLE && trip && !rend |=> st.hs1)
    else $error("ripple trip did not fire gate");
  no_hs2_single_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !st.two_ph |=> !st.hs2 || $past(st.two_ph))
    else $error("phase two pulsed in single phase");
  heavy_dual_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !next_st.window && psh && !dsh && !strap |=> st.two_ph)
    else $error("heavy load did not run two phases");
  light_drop_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !next_st.window && (!psh || dsh) |=> !st.two_ph)
    else $error("light load kept two phases");
  window_end_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    st.window && st.mask_cnt == '0 && code == st.prev_code
    |=> !st.window)
    else $error("transition window overran");
  turn_fire_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    st.mode == pms_pkg::PMS_FIXED && st.two_ph && st.turn && mc.tick
    && !rend |=> st.hs2)
    else $error("phase two missed its master tick");
endmodule // pms_top

//--- tb_pms_top.sv
// self-checking bench for the phase and mode selector
`timescale 1ns/1ps
module tb_pms_top;
  logic       clock_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       strap = 1'b0;
  logic       cl = 1'b0;
  logic       trip = 1'b0;
  logic       zc = 1'b0;
  logic [8:0] cmd = 9'h000;
  logic [8:0] pins;
  logic       re;
  logic       h1, l1, h2, l2, two, fix, ripple_triggered_mode, dcm, win;
  logic [6:0] code;
  int         num_errors = 0;
  int         checks = 0;
  int         cycles = 0;
  always #2 clock_i = ~clock_i;
  pms_host host (.clock_i(clock_i), .cmd_i(cmd), .on_len_i(8'h14),
    .gate_i(h1 | h2), .pins_o(pins), .ramp_end_o(re));
  pms_top uut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .phase_count_strap_i(strap), .power_state_hint_i(pins[8]),
    .deep_sleep_hint_i(pins[7]), .voltage_code_i(pins[6:0]),
    .current_limit_i(cl), .ripple_trip_i(trip), .ramp_end_i(re),
    .zero_current_i(zc), .phase1_high_gate_o(h1), .phase1_low_gate_o(l1),
    .phase2_high_gate_o(h2), .phase2_low_gate_o(l2), .two_phase_o(two),
    .fixed_clock_mode_o(fix), .ripple_triggered_mode_o(ripple_triggered_mode),
    .dcm_allowed_o(dcm), .code_transition_o(win), .voltage_code_o(code));
  task automatic close_out();
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic check_bit(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic check_code(input logic [6:0] got, input logic [6:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t code out", $time);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // cycles between two rising edges of the phase one high gate
  task automatic h1_gap(output int gap);
    int t0;
    @(posedge h1);
    t0 = cycles;
    @(posedge h1);
    gap = cycles - t0;
  endtask
  // hint pair and code reach mode outputs within ten edges
  task automatic hints(input logic p, input logic s, input logic [6:0] c);
    cmd <= {p, s, c};
    step(10);
  endtask
  task automatic modes(input logic t, input logic f, input logic r,
                       input logic d);
    check_bit(two, t, "phases");
    check_bit(fix, f, "fixed");
    check_bit(ripple_triggered_mode, r, "ripple");
    check_bit(dcm, d, "dcm");
  endtask
  task automatic t_heavy();
    int n1, n2, bad;
    logic p1, p2, last;
    n1 = 0; n2 = 0; bad = 0; p1 = 0; p2 = 0; last = 1'b1;
    hints(1'b1, 1'b0, 7'h00);
    modes(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (2200) begin
      @(posedge clock_i);
      if (h1 && !p1) begin n1++; bad += (last == 1'b0); last = 1'b0; end
      if (h2 && !p2) begin n2++; bad += (last == 1'b1); last = 1'b1; end
      p1 = h1; p2 = h2;
    end
    check_bit(n1 >= 2 && n2 >= 2, 1'b1, "both phases run");
    check_bit(bad == 0, 1'b1, "phases alternate");
  endtask
  task automatic t_light();
    hints(1'b0, 1'b0, 7'h00);
    modes(1'b0, 1'b0, 1'b1, 1'b0);
    trip <= 1'b1;
    step(2);
    trip <= 1'b0;
    step(8);
    check_bit(h1, 1'b1, "ripple start");
    check_bit(l1, 1'b0, "low off while high");
    check_bit(l2, 1'b0, "phase two idle");
  endtask
  task automatic t_sleep();
    hints(1'b0, 1'b1, 7'h00);
    modes(1'b0, 1'b0, 1'b1, 1'b1);
    step(40);
    zc <= 1'b1;
    step(2);
    zc <= 1'b0;
    step(8);
    check_bit(l1, 1'b0, "low side stops at zero");
    cl <= 1'b1;
    step(10);
    modes(1'b0, 1'b1, 1'b0, 1'b0);
    cl <= 1'b0;
  endtask
  task automatic t_strap();
    strap <= 1'b1;
    hints(1'b1, 1'b0, 7'h00);
    modes(1'b0, 1'b1, 1'b0, 1'b0);
    strap <= 1'b0;
    step(10);
  endtask
  task automatic t_window();
    hints(1'b0, 1'b0, 7'h40);
    check_bit(win, 1'b1, "window open");
    check_bit(two, 1'b1, "user phases");
    check_bit(fix, 1'b1, "window fixed clock");
    check_code(code, 7'h40);
    step(12000);
    hints(1'b0, 1'b0, 7'h41);
    step(pms_pkg::MASK_CYC - 30);
    check_bit(win, 1'b1, "window restarted");
    step(40);
    check_bit(win, 1'b0, "window closed");
    modes(1'b0, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_rate();
    int a, b, c, d;
    strap <= 1'b1;
    hints(1'b1, 1'b0, 7'h00);
    h1_gap(a);
    h1_gap(a);
    h1_gap(b);
    check_bit(a == b, 1'b1, "clock steady at one code");
    hints(1'b1, 1'b0, 7'h7f);
    h1_gap(c);
    h1_gap(c);
    check_bit(c < a, 1'b1, "clock slower at lower code");
    strap <= 1'b0;
    hints(1'b1, 1'b0, 7'h7f);
    h1_gap(d);
    h1_gap(d);
    check_bit(d == 2 * c, 1'b1, "rate split over two phases");
  endtask
  initial begin
    step(2);
    rst_b_i <= 1'b1;
    step(1);
    check_bit(h1, 1'b0, "reset gate");
    check_bit(l1, 1'b1, "reset low gate");
    check_bit(win, 1'b0, "reset window");
    t_heavy();
    t_light();
    t_sleep();
    t_strap();
    t_window();
    t_rate();
    close_out();
  end
endmodule // tb_pms_top
